// >>> logic/rps_status_bank.sv
// per-port status register bank behind the byte-wide register port
`timescale 1ns/1ns
`include "rps_regs.svh"
module rps_status_bank (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire rps_pkg::rps_byte_t      reg_addr,
   input  wire rps_pkg::rps_byte_t      reg_wdata,
   output rps_pkg::rps_byte_t           reg_rdata,
   input  wire rps_pkg::rps_port_mask_t line_width_unsteady_evt,
   input  wire rps_pkg::rps_port_mask_t line_width_changed_evt,
   input  wire rps_pkg::rps_port_mask_t link_coding_fault_evt,
   input  wire rps_pkg::rps_port_mask_t buffer_overflow_evt,
   input  wire rps_pkg::rps_port_mask_t line_total_changed_evt,
   input  wire rps_pkg::rps_port_mask_t camera_rx_fault_detail,
   input  wire rps_pkg::rps_port_mask_t rate_measure_settled,
   input  wire rps_pkg::rps_port_mask_t rate_sample_valid,
   input  wire rps_pkg::rps_byte_t      rate_integer_byte [`RPS_NPORTS],
   input  wire rps_pkg::rps_byte_t      rate_fraction_byte [`RPS_NPORTS],
   input  wire rps_pkg::rps_byte_t      rate_low_limit,
   input  wire rps_pkg::rps_byte_t      link_fault_tally_limit,
   input  wire rps_pkg::rps_port_mask_t remote_load,
   input  wire rps_pkg::rps_byte_t      remote_status_zero_in [`RPS_NPORTS],
   input  wire rps_pkg::rps_byte_t      remote_status_one_in [`RPS_NPORTS],
   output rps_pkg::rps_port_mask_t      link_clock_absent,
   output rps_pkg::rps_byte_t           port_select
);
   import rps_pkg::*;

   rps_byte_t      sel_q, sel_d, rdata_q, rdata_d;
   rps_byte_t      fint_q [`RPS_NPORTS];
   rps_byte_t      ffrac_q [`RPS_NPORTS];
   rps_byte_t      fint_d [`RPS_NPORTS];
   rps_byte_t      ffrac_d [`RPS_NPORTS];
   rps_byte_t      flags [`RPS_NPORTS];
   rps_byte_t      sens0 [`RPS_NPORTS];
   rps_byte_t      sens1 [`RPS_NPORTS];
   rps_port_mask_t clr_vec, absent_q, absent_d, coding_gate;
   rps_port_t      rd_port;

   // the selected port for reads: lowest set bit of the select mask
   function automatic rps_port_t first_port(input rps_byte_t m);
      rps_port_t p;
      p = 2'h0;
      for (int i = `RPS_NPORTS - 1; i >= 0; i--) begin
         if (m[i]) begin
            p = rps_port_t'(i);
         end
      end
      return p;
   endfunction

   // a read of the per-port status byte: it answers and clears in the same edge
   function automatic logic status_read(input logic rd, input rps_byte_t a);
      return rd && (a == `RPS_STS2_ADDR);
   endfunction

   // ==========================================================
   // port select, clearing reads and rate capture
   always_comb begin
      sel_d = sel_q;
      if (reg_wr && reg_addr == `RPS_PORT_SEL_ADDR) begin
         sel_d = reg_wdata;
      end
      rd_port = first_port(sel_q);
      clr_vec = 4'h0;
      if (status_read(reg_rd, reg_addr)) begin
         clr_vec[rd_port] = 1'b1;
      end
      // coding errors only surface when the tally limit keeps lock alive
      coding_gate = (link_fault_tally_limit > `RPS_TALLY_LIMIT_MIN) ? 4'hF : 4'h0;
      for (int i = 0; i < `RPS_NPORTS; i++) begin
         fint_d[i]   = rate_sample_valid[i] ? rate_integer_byte[i] : fint_q[i];
         ffrac_d[i]  = rate_sample_valid[i] ? rate_fraction_byte[i] : ffrac_q[i];
         absent_d[i] = fint_d[i] < rate_low_limit;
      end
   end

   // ==========================================================
   // read data mux, registered so the byte holds after the strobe
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd) begin
         case (reg_addr)
            `RPS_PORT_SEL_ADDR:  rdata_d = sel_q;
            `RPS_STS2_ADDR: begin
               rdata_d = flags[rd_port];
               rdata_d[`RPS_BIT_CAMERA_FAULT] = camera_rx_fault_detail[rd_port];
               rdata_d[`RPS_BIT_RATE_SETTLED] = rate_measure_settled[rd_port];
               rdata_d[`RPS_BIT_CLOCK_ABSENT] = absent_q[rd_port];
            end
            `RPS_FREQ_INT_ADDR:  rdata_d = fint_q[rd_port];
            `RPS_FREQ_FRAC_ADDR: rdata_d = ffrac_q[rd_port];
            `RPS_SENS0_ADDR:     rdata_d = sens0[rd_port];
            `RPS_SENS1_ADDR:     rdata_d = sens1[rd_port];
            default:             rdata_d = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q    <= `RPS_PORT_SEL_RESET;
         rdata_q  <= `RPS_BYTE_RESET;
         absent_q <= 4'h0;
         for (int i = 0; i < `RPS_NPORTS; i++) begin
            fint_q[i]  <= `RPS_BYTE_RESET;
            ffrac_q[i] <= `RPS_BYTE_RESET;
         end
      end else begin
         sel_q    <= sel_d;
         rdata_q  <= rdata_d;
         absent_q <= absent_d;
         for (int i = 0; i < `RPS_NPORTS; i++) begin
            fint_q[i]  <= fint_d[i];
            ffrac_q[i] <= ffrac_d[i];
         end
      end
   end

   // ==========================================================
   // one flag bank per port
   for (genvar g = 0; g < `RPS_NPORTS; g++) begin : g_port
      rps_port_flags u_flags (
         .ref_clk                 (ref_clk),
         .rst_n                   (rst_n),
         .line_width_unsteady_evt (line_width_unsteady_evt[g]),
         .line_width_changed_evt  (line_width_changed_evt[g]),
         .link_coding_fault_evt   (link_coding_fault_evt[g] & coding_gate[g]),
         .buffer_overflow_evt     (buffer_overflow_evt[g]),
         .line_total_changed_evt  (line_total_changed_evt[g]),
         .status_clear            (clr_vec[g]),
         .remote_load             (remote_load[g]),
         .remote_status_zero_in   (remote_status_zero_in[g]),
         .remote_status_one_in    (remote_status_one_in[g]),
         .sticky_flags            (flags[g]),
         .remote_status_byte_zero (sens0[g]),
         .remote_status_byte_one  (sens1[g])
      );
   end

   assign reg_rdata         = rdata_q;
   assign link_clock_absent = absent_q;
   assign port_select       = sel_q;

   // ==========================================================
   // checks on what the bank drives
   a_read_clears_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `RPS_STS2_ADDR && rd_port == 2'h0 && !line_width_changed_evt[0])
      |=> !flags[0][`RPS_BIT_LEN_CHANGED])
      else $error("flag not cleared by read");
   a_flag_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      buffer_overflow_evt[1] |=> flags[1][`RPS_BIT_BUFFER_FAULT])
      else $error("overflow flag not set");
   a_absent_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fint_d[2] < rate_low_limit) |=> link_clock_absent[2])
      else $error("clock absent not reported");
   a_coding_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (link_fault_tally_limit <= `RPS_TALLY_LIMIT_MIN && !flags[0][5] && !clr_vec[0]) |=> !flags[0][5])
      else $error("coding flag set with low tally limit");
   a_unsteady_sticks: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (flags[3][7] && !clr_vec[3]) |=> flags[3][7])
      else $error("unsteady flag dropped without read");
   a_total_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      line_total_changed_evt[0] |=> flags[0][0])
      else $error("line count flag not set");
   a_rate_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `RPS_FREQ_INT_ADDR) |=> reg_rdata == $past(fint_q[rd_port]))
      else $error("rate byte read wrong");
   a_sel_steer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `RPS_STS2_ADDR && sel_q == 8'h02) |-> clr_vec == 4'h2)
      else $error("read steered to wrong port");
   a_camera_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_read(reg_rd, reg_addr)
      |=> reg_rdata[`RPS_BIT_CAMERA_FAULT] == $past(camera_rx_fault_detail[rd_port]))
      else $error("camera fault bit not shown live");
   a_settled_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
      status_read(reg_rd, reg_addr)
      |=> reg_rdata[`RPS_BIT_RATE_SETTLED] == $past(rate_measure_settled[rd_port]))
      else $error("settled bit not shown live");
   a_frac_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `RPS_FREQ_FRAC_ADDR)
      |=> reg_rdata == $past(ffrac_q[rd_port]))
      else $error("fraction byte read wrong");
   a_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `RPS_PORT_SEL_ADDR)
      |=> port_select == $past(reg_wdata))
      else $error("port select write lost");
   a_write_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr != `RPS_PORT_SEL_ADDR)
      |=> port_select == $past(port_select))
      else $error("write to a read-only byte moved the port select");
   a_coding_passes: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (link_fault_tally_limit > `RPS_TALLY_LIMIT_MIN && link_coding_fault_evt[0])
      |=> flags[0][`RPS_BIT_CODING_FAULT])
      else $error("coding flag missed with tally limit above one");
   a_sensor_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
      remote_load[3]
      |=> sens0[3] == $past(remote_status_zero_in[3]) && sens1[3] == $past(remote_status_one_in[3]))
      else $error("forwarded status bytes not captured");

   // a rate sample on port 2, one quiet cycle, then a read of its integer byte
   sequence s_sample_then_read;
      rate_sample_valid[2] ##1 !rate_sample_valid[2]
      ##1 (reg_rd && reg_addr == `RPS_FREQ_INT_ADDR && rd_port == 2'h2 && !rate_sample_valid[2]);
   endsequence
   a_rate_after_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_sample_then_read |=> reg_rdata == $past(rate_integer_byte[2], 3))
      else $error("integer rate byte does not match its sample");
endmodule

// >>> logic/rps_regs.svh
// register offsets, field positions, reset values and counts of the rx port status bank
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
`define RPS_PORT_SEL_ADDR      8'h4C
`define RPS_STS2_ADDR          8'h4E
`define RPS_FREQ_INT_ADDR      8'h4F
`define RPS_FREQ_FRAC_ADDR     8'h50
`define RPS_SENS0_ADDR         8'h51
`define RPS_SENS1_ADDR         8'h52
`define RPS_BIT_LEN_UNSTEADY   7
`define RPS_BIT_LEN_CHANGED    6
`define RPS_BIT_CODING_FAULT   5
`define RPS_BIT_BUFFER_FAULT   4
`define RPS_BIT_CAMERA_FAULT   3
`define RPS_BIT_RATE_SETTLED   2
`define RPS_BIT_CLOCK_ABSENT   1
`define RPS_BIT_TOTAL_CHANGED  0
`define RPS_STS2_RESET         8'h00
`define RPS_BYTE_RESET         8'h00
`define RPS_PORT_SEL_RESET     8'h01
`define RPS_NPORTS             4
`define RPS_TALLY_LIMIT_MIN    8'h01
`endif

// >>> logic/rps_pkg.sv
// types shared by the rx port status bank
package rps_pkg;
   typedef logic [7:0] rps_byte_t;
   typedef logic [3:0] rps_port_mask_t;
   typedef logic [1:0] rps_port_t;
endpackage

// >>> logic/rps_port_flags.sv
// one receive port's sticky status flags and mirrored bytes
`timescale 1ns/1ns
`include "rps_regs.svh"
module rps_port_flags (
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire logic           line_width_unsteady_evt,
   input  wire logic           line_width_changed_evt,
   input  wire logic           link_coding_fault_evt,
   input  wire logic           buffer_overflow_evt,
   input  wire logic           line_total_changed_evt,
   input  wire logic           status_clear,
   input  wire logic           remote_load,
   input  wire rps_pkg::rps_byte_t remote_status_zero_in,
   input  wire rps_pkg::rps_byte_t remote_status_one_in,
   output rps_pkg::rps_byte_t  sticky_flags,
   output rps_pkg::rps_byte_t  remote_status_byte_zero,
   output rps_pkg::rps_byte_t  remote_status_byte_one
);
   import rps_pkg::*;
   rps_byte_t flags_q, flags_d, sens0_q, sens0_d, sens1_q, sens1_d;
   rps_byte_t set_vec;

   // ==========================================================
   // sticky flags: a new event beats a clearing read
   always_comb begin
      set_vec = 8'h00;
      set_vec[`RPS_BIT_LEN_UNSTEADY]  = line_width_unsteady_evt;
      set_vec[`RPS_BIT_LEN_CHANGED]   = line_width_changed_evt;
      set_vec[`RPS_BIT_CODING_FAULT]  = link_coding_fault_evt;
      set_vec[`RPS_BIT_BUFFER_FAULT]  = buffer_overflow_evt;
      set_vec[`RPS_BIT_TOTAL_CHANGED] = line_total_changed_evt;
      flags_d = (status_clear ? 8'h00 : flags_q) | set_vec;
      sens0_d = remote_load ? remote_status_zero_in : sens0_q;
      sens1_d = remote_load ? remote_status_one_in : sens1_q;
   end

   // ==========================================================
   // storage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= `RPS_STS2_RESET;
         sens0_q <= `RPS_BYTE_RESET;
         sens1_q <= `RPS_BYTE_RESET;
      end else begin
         flags_q <= flags_d;
         sens0_q <= sens0_d;
         sens1_q <= sens1_d;
      end
   end

   assign sticky_flags            = flags_q;
   assign remote_status_byte_zero = sens0_q;
   assign remote_status_byte_one  = sens1_q;

   a_flag_survives_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (status_clear && line_width_changed_evt) |=> flags_q[`RPS_BIT_LEN_CHANGED])
      else $error("event lost in clearing read");
endmodule

// >>> sim/rps_far_model.sv
// far-side serializer model: link events, rate samples and forwarded status bytes
`timescale 1ns/1ns
module rps_far_model (
   input  wire logic             ref_clk,
   output rps_pkg::rps_port_mask_t ev [5],
   output rps_pkg::rps_port_mask_t rate_valid,
   output rps_pkg::rps_byte_t    rate_int [4],
   output rps_pkg::rps_byte_t    rate_frac [4],
   output rps_pkg::rps_port_mask_t load,
   output rps_pkg::rps_byte_t    st0 [4],
   output rps_pkg::rps_byte_t    st1 [4]
);
   import rps_pkg::*;
   // idle data lines carry junk so a capture outside its strobe shows up
   initial begin
      ev = '{default: 4'h0};
      rate_valid = 4'h0;
      load = 4'h0;
      rate_int = '{default: 8'h5A};
      rate_frac = '{default: 8'hA5};
      st0 = '{default: 8'h5A};
      st1 = '{default: 8'hA5};
   end
   // one-cycle event pulse of kind k on port p
   task pulse(input int k, input int p);
      @(negedge ref_clk);
      ev[k][p] = 1'b1;
      @(negedge ref_clk);
      ev[k][p] = 1'b0;
   endtask
   // one rate sample, then the bytes turn to their inverse
   task rate(input int p, input rps_byte_t i, input rps_byte_t f);
      @(negedge ref_clk);
      rate_int[p] = i;
      rate_frac[p] = f;
      rate_valid[p] = 1'b1;
      @(negedge ref_clk);
      rate_valid[p] = 1'b0;
      rate_int[p] = ~i;
      rate_frac[p] = ~f;
   endtask
   // forwarded sensor status pair
   task send(input int p, input rps_byte_t z, input rps_byte_t o);
      @(negedge ref_clk);
      st0[p] = z;
      st1[p] = o;
      load[p] = 1'b1;
      @(negedge ref_clk);
      load[p] = 1'b0;
      st0[p] = ~z;
      st1[p] = ~o;
   endtask
endmodule

// >>> sim/rps_status_bank_test.sv
// self-checking bench of the rx port status bank
`timescale 1ns/1ns
`include "rps_regs.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module rps_status_bank_test;
   import rps_pkg::*;
   logic ref_clk, rst_n, reg_wr, reg_rd;
   rps_byte_t reg_addr, reg_wdata, reg_rdata, low_lim, tally, port_select;
   rps_port_mask_t cam, settled, lca, ev [5], rv, ld;
   rps_byte_t ri [4], rf [4], s0 [4], s1 [4], d;
   int err_count = 0;
   int comparisons = 0;
   int bp [5] = '{7, 6, 5, 4, 0};
   rps_far_model i_rps_far_model (.ref_clk(ref_clk), .ev(ev), .rate_valid(rv), .rate_int(ri),
      .rate_frac(rf), .load(ld), .st0(s0), .st1(s1));
   rps_status_bank i_rps_status_bank (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_width_unsteady_evt(ev[0]),
      .line_width_changed_evt(ev[1]), .link_coding_fault_evt(ev[2]), .buffer_overflow_evt(ev[3]),
      .line_total_changed_evt(ev[4]), .camera_rx_fault_detail(cam), .rate_measure_settled(settled),
      .rate_sample_valid(rv), .rate_integer_byte(ri), .rate_fraction_byte(rf), .rate_low_limit(low_lim),
      .link_fault_tally_limit(tally), .remote_load(ld), .remote_status_zero_in(s0),
      .remote_status_one_in(s1), .link_clock_absent(lca), .port_select(port_select));
   always #5 ref_clk = ~ref_clk;
   // ==========================
   // register access tasks
   task wr(input rps_byte_t a, input rps_byte_t v);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   // read data lands one edge after the strobe
   task rd(input rps_byte_t a, output rps_byte_t v);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   task chk(input rps_byte_t a, input rps_byte_t e);
      rps_byte_t v;
      rd(a, v);
      `CHK($sformatf("reg %h", a), e, v)
   endtask
   task stop_test;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================
   // test sequence
   initial begin
      ref_clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      cam = 4'h0; settled = 4'h0; low_lim = 8'h00; tally = 8'h01;
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      `CHK("port_select", 8'h01, port_select)
      for (int a = 'h4e; a <= 'h52; a++) chk(rps_byte_t'(a), 8'h00);
      chk(8'h4d, 8'h00);
      wr(8'h4e, 8'hff);
      chk(8'h4e, 8'h00);
      i_rps_far_model.pulse(2, 0);
      chk(8'h4e, 8'h00);
      tally = 8'h02;
      // every sticky flag on every port, seen only through its own port
      for (int p = 0; p < 4; p++) begin
         for (int k = 0; k < 5; k++) begin
            i_rps_far_model.pulse(k, p);
            wr(8'h4c, rps_byte_t'(1 << ((p + 1) % 4)));
            chk(8'h4e, 8'h00);
            wr(8'h4c, rps_byte_t'(1 << p));
            chk(8'h4e, rps_byte_t'(1 << bp[k]));
            chk(8'h4e, 8'h00);
         end
      end
      // event landing on the clearing read must survive it
      wr(8'h4c, 8'h01);
      fork
         rd(8'h4e, d);
         i_rps_far_model.pulse(1, 0);
      join
      `CHK("read before event", 8'h00, d)
      chk(8'h4e, 8'h40);
      cam = 4'h4;
      settled = 4'h4;
      wr(8'h4c, 8'h04);
      chk(8'h4e, 8'h0c);
      chk(8'h4e, 8'h0c);
      i_rps_far_model.rate(2, 8'h2a, 8'h80);
      chk(8'h4f, 8'h2a);
      chk(8'h50, 8'h80);
      low_lim = 8'h30;
      repeat (2) @(negedge ref_clk);
      `CHK("link_clock_absent", 4'hf, lca)
      chk(8'h4e, 8'h0e);
      i_rps_far_model.rate(2, 8'h40, 8'h01);
      repeat (2) @(negedge ref_clk);
      `CHK("link_clock_absent", 4'hb, lca)
      chk(8'h4e, 8'h0c);
      i_rps_far_model.send(3, 8'ha5, 8'h3c);
      chk(8'h51, 8'h00);
      wr(8'h4c, 8'h08);
      `CHK("port_select", 8'h08, port_select)
      chk(8'h51, 8'ha5);
      chk(8'h52, 8'h3c);
      // a second reset in mid-run must wipe loaded bytes and captured rates
      @(negedge ref_clk);
      rst_n = 1'b0;
      @(negedge ref_clk);
      rst_n = 1'b1;
      `CHK("port_select", 8'h01, port_select)
      wr(8'h4c, 8'h08);
      chk(8'h51, 8'h00);
      chk(8'h52, 8'h00);
      wr(8'h4c, 8'h04);
      chk(8'h4f, 8'h00);
      chk(8'h50, 8'h00);
      chk(8'h4e, 8'h0e);
      stop_test;
   end
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      stop_test;
   end
endmodule
